// ---- dv/mms_bank_tb.sv ----
`timescale 1ns/1ps
module mms_bank_tb
  import mms_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  mms_loop_s   lp;
  mms_state_s  st;
  logic        lsd;
  logic [31:0] slo;
  logic [31:0] shi;
  logic [15:0] ain;
  logic [13:0] xa [4];
  logic        lls;
  logic        hls;
  logic [3:0]  dpin;
  logic [7:0]  xdp;
  logic [31:0] cap_lo;
  logic [31:0] cap_hi;
  logic        seen_pwr;
  int          fail_count;
  int          checks_done;
  int          seed;

  always #4 core_clk = ~core_clk;

  mms_host i_mms_host (.core_clk(core_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  mms_bank i_mms_bank (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .loop_in(lp), .state_in(st),
    .limit_search_done(lsd), .search_lower_in(slo), .search_upper_in(shi),
    .analog_in(ain), .ext_analog_in1(xa[0]), .ext_analog_in2(xa[1]),
    .ext_analog_in3(xa[2]), .ext_analog_in4(xa[3]),
    .low_limit_switch(lls), .high_limit_switch(hls),
    .digital_in_pins(dpin), .ext_digital_pins(xdp));

  function automatic logic [31:0] sx16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  function automatic logic [31:0] sx14(input logic [13:0] v);
    return {{18{v[13]}}, v};
  endfunction

  // Expected word for an index, from what the bench drives.
  function automatic logic [31:0] model(input logic [7:0] a);
    longint sn;
    longint cs;
    longint s;
    sn = $signed(lp.encoder_sine);
    cs = $signed(lp.encoder_cosine);
    s = sn * sn + cs * cs;
    case (a)
      IDX_LUT_PHASE1: return sx16(lp.lut_phase1);
      IDX_LUT_PHASE2: return sx16(lp.lut_phase2);
      IDX_VOLTAGE_REF: return lp.voltage_ref_phase1;
      IDX_FORCE_AFTER: return sx16(lp.force_after_adv_filter);
      IDX_REAL_FORCE: return sx16(lp.real_force);
      IDX_FORCE_BEFORE: return sx16(lp.force_before_adv_filter);
      IDX_SEARCH_LOWER: return cap_lo;
      IDX_SEARCH_UPPER: return cap_hi;
      IDX_ENC_SINE: return sx16(lp.encoder_sine);
      IDX_ENC_COSINE: return sx16(lp.encoder_cosine);
      IDX_ENC_AMP_SQ: return (s > 4194304) ? 32'h0040_0000 : s[31:0];
      IDX_ENC_LIMITS: return {30'h0, hls, lls};
      IDX_DIGITAL_INPUTS: return {22'h0, dpin[3:2], 6'h0, dpin[1:0]};
      IDX_ANALOG_INPUT: return sx16(ain);
      IDX_EXT_DIGITAL: return {24'h0, xdp};
      IDX_EXT_ANALOG1: return sx14(xa[0]);
      IDX_EXT_ANALOG2: return sx14(xa[1]);
      IDX_EXT_ANALOG3: return sx14(xa[2]);
      IDX_EXT_ANALOG4: return sx14(xa[3]);
      IDX_STATUS_ONE: return {8'h0, st.warning, 9'h0,
        st.homing_active, 1'b0, st.trace_busy,
        st.error_mode, st.seq_edit, st.seq_running, st.waiting,
        1'b0, st.in_window, st.moving, 1'b1,
        st.homing_done_ok, seen_pwr, st.powered};
      IDX_STATUS_TWO: return {31'h0, st.seq_error_label};
      default: return 32'h0;
    endcase
  endfunction

  task automatic check(input string what, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  // Indices 0-63 and ff are each written with junk first, so a bank that takes writes
  // shows it on the read that follows.
  task automatic pass_all();
    logic [31:0] d;
    logic [7:0]  a;
    for (int i = 0; i < 65; i++) begin
      a = (i == 64) ? 8'hff : 8'(i);
      i_mms_host.wr(a, $urandom);
      i_mms_host.rd(a, d);
      check($sformatf("reg %h", a), model(a), d);
    end
  endtask

  task automatic zero_in();
    lp <= '0;
    st <= '0;
    lsd <= 1'b0;
    slo <= '0;
    shi <= '0;
    ain <= '0;
    lls <= 1'b0;
    hls <= 1'b0;
    dpin <= '0;
    xdp <= '0;
    for (int i = 0; i < 4; i++) begin
      xa[i] <= '0;
    end
    cap_lo = '0;
    cap_hi = '0;
    seen_pwr = 1'b0;
  endtask

  task automatic stim(input int k);
    logic [255:0] r;
    mms_loop_s    tl;
    mms_state_s   ts;
    for (int i = 0; i < 8; i++) begin
      r[i*32 +: 32] = $urandom;
    end
    tl = r[143:0];
    ts = r[156:144];
    if (k == 0) begin
      ts.power_on_command = 1'b0;
    end
    if (k == 1) begin
      tl.encoder_sine = 16'h04b0;
      tl.encoder_cosine = 16'hfc18;
    end
    if (k == 2) begin
      tl.encoder_sine = 16'h8000;
      tl.encoder_cosine = 16'h8000;
    end
    cap_lo = $urandom;
    cap_hi = $urandom;
    @(posedge core_clk);
    lp <= tl;
    st <= ts;
    dpin <= r[160:157];
    xdp <= r[168:161];
    lls <= r[169];
    hls <= r[170];
    ain <= r[186:171];
    for (int i = 0; i < 4; i++) begin
      xa[i] <= r[187+14*i +: 14];
    end
    slo <= cap_lo;
    shi <= cap_hi;
    lsd <= 1'b1;
    @(posedge core_clk);
    lsd <= 1'b0;
    slo <= ~cap_lo;
    shi <= ~cap_hi;
    seen_pwr = seen_pwr | ts.power_on_command;
    // Pins pass a synchroniser, so let them settle before reading.
    repeat (8) @(posedge core_clk);
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    fail_count++;
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    zero_in();
    seed = $urandom(97);
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    pass_all();
    for (int k = 0; k < 20; k++) begin
      stim(k);
      pass_all();
    end
    @(posedge core_clk);
    rst_n <= 1'b0;
    zero_in();
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    pass_all();
    end_of_test();
  end
endmodule // mms_bank_tb

// ---- dv/mms_host.sv ----
`timescale 1ns/1ps
// Host side of the register port. Strobes last one cycle, read data is
// taken at the edge that closes the answer cycle.
module mms_host (
  // Clock
  input  wire logic        core_clk,
  // Register port
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask
endmodule // mms_host

// ---- inc/mms_pkg.sv ----
package mms_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_LUT_PHASE1      = 8'h19;
  localparam logic [7:0] IDX_LUT_PHASE2      = 8'h1a;
  localparam logic [7:0] IDX_VOLTAGE_REF     = 8'h1d;
  localparam logic [7:0] IDX_FORCE_AFTER     = 8'h1e;
  localparam logic [7:0] IDX_REAL_FORCE      = 8'h1f;
  localparam logic [7:0] IDX_FORCE_BEFORE    = 8'h20;
  localparam logic [7:0] IDX_SEARCH_LOWER    = 8'h24;
  localparam logic [7:0] IDX_SEARCH_UPPER    = 8'h25;
  localparam logic [7:0] IDX_ENC_SINE        = 8'h28;
  localparam logic [7:0] IDX_ENC_COSINE      = 8'h29;
  localparam logic [7:0] IDX_ENC_AMP_SQ      = 8'h2b;
  localparam logic [7:0] IDX_ENC_LIMITS      = 8'h2c;
  localparam logic [7:0] IDX_DIGITAL_INPUTS  = 8'h32;
  localparam logic [7:0] IDX_ANALOG_INPUT    = 8'h33;
  localparam logic [7:0] IDX_EXT_DIGITAL     = 8'h37;
  localparam logic [7:0] IDX_EXT_ANALOG1     = 8'h38;
  localparam logic [7:0] IDX_EXT_ANALOG2     = 8'h39;
  localparam logic [7:0] IDX_EXT_ANALOG3     = 8'h3a;
  localparam logic [7:0] IDX_EXT_ANALOG4     = 8'h3b;
  localparam logic [7:0] IDX_STATUS_ONE      = 8'h3c;
  localparam logic [7:0] IDX_STATUS_TWO      = 8'h3d;

  // Status word one bit positions.
  localparam int ST1_POWERED   = 0;
  localparam int ST1_INIT_ONCE = 1;
  localparam int ST1_HOMED     = 2;
  localparam int ST1_PRESENT   = 3;
  localparam int ST1_MOVING    = 4;
  localparam int ST1_IN_WINDOW = 5;
  localparam int ST1_WAITING   = 7;
  localparam int ST1_SEQ_RUN   = 8;
  localparam int ST1_SEQ_EDIT  = 9;
  localparam int ST1_ERROR     = 10;
  localparam int ST1_TRACE     = 11;
  localparam int ST1_HOMING    = 13;
  localparam int ST1_WARNING   = 23;
  localparam int ST2_SEQ_ERR   = 0;

  localparam logic [31:0] ST1_RESET = 32'h0000_0008;
  localparam logic [31:0] ST2_RESET = 32'h0000_0000;
  localparam logic [22:0] AMP_SQ_MAX = 23'h40_0000;
  localparam logic [12:0] EXT_AN_MAX = 13'h1fff;
  localparam int EXT_AN_WIDTH = 14;
  localparam int SYNC_WIDTH = 14;

  // Values from the controller's regulators and encoder interface.
  typedef struct packed {
    logic [15:0] lut_phase1;
    logic [15:0] lut_phase2;
    logic [31:0] voltage_ref_phase1;
    logic [15:0] force_after_adv_filter;
    logic [15:0] real_force;
    logic [15:0] force_before_adv_filter;
    logic [15:0] encoder_sine;
    logic [15:0] encoder_cosine;
  } mms_loop_s;

  // Status events from the sequence engine.
  typedef struct packed {
    logic powered;
    logic power_on_command;
    logic homing_done_ok;
    logic homing_active;
    logic moving;
    logic in_window;
    logic waiting;
    logic seq_running;
    logic seq_edit;
    logic error_mode;
    logic trace_busy;
    logic warning;
    logic seq_error_label;
  } mms_state_s;

endpackage

// ---- verilog/mms_bank.sv ----
`timescale 1ns/1ps
// Function
// - Status one bit 0 reads 1 while powered on.
// - Status one bit 1 sets on first power-on command and stays set.
// - Status one bit 2 sets when homing completes successfully.
// - Status one bit 3 always reads 1; reset value is 8.
// - Status one bit 4 set while a trajectory runs.
// - Status one bit 5 set while inside position/time window.
// - Bit 7 shows waiting; bit 8 shows internal sequence running.
// - Bit 9 shows sequence edit mode.
// - Bit 10 shows error mode; bit 23 shows global warning.
// - Bit 11 held high through a register trace acquisition.
// - Bit 13 set while homing is in progress.
// - Status two bit 0 shows pending sequence error label; reset 0.
// - Digital inputs at bits 0-1 and 8-9, bits 2-7 zero.
// - Limit word: low switch bit 0, high switch bit 1.
// - Encoder sine and cosine are signed 16-bit monitors.
// - Sum of squared sine and cosine, capped at 4194304.
// - Limit search captures lower and upper signed 32-bit positions.
// - Eight expansion digital inputs in one byte-wide word.
// - Four expansion analog inputs, signed 14-bit ranged values.
// - Three force monitors, each signed 16-bit.
// - Lookup values signed 16-bit; phase 1 voltage reference 32-bit.
module mms_bank
  import mms_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Internal controller sources
  input  wire mms_loop_s   loop_in,
  input  wire mms_state_s  state_in,
  input  wire logic        limit_search_done,
  input  wire logic [31:0] search_lower_in,
  input  wire logic [31:0] search_upper_in,
  input  wire logic [15:0] analog_in,
  input  wire logic [13:0] ext_analog_in1,
  input  wire logic [13:0] ext_analog_in2,
  input  wire logic [13:0] ext_analog_in3,
  input  wire logic [13:0] ext_analog_in4,
  // Pins
  input  wire logic        low_limit_switch,
  input  wire logic        high_limit_switch,
  input  wire logic [3:0]  digital_in_pins,
  input  wire logic [7:0]  ext_digital_pins
);

  default clocking bank_clk @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Pin inputs pass three flops; a change counts when the last two agree.
  logic [SYNC_WIDTH-1:0] pin_raw;
  logic [SYNC_WIDTH-1:0] sync_a;
  logic [SYNC_WIDTH-1:0] sync_b;
  logic [SYNC_WIDTH-1:0] sync_c;
  logic [SYNC_WIDTH-1:0] pin_clean;

  assign pin_raw = {ext_digital_pins, digital_in_pins,
                    high_limit_switch, low_limit_switch};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_WIDTH; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync_a[gi]    <= 1'b0;
          sync_b[gi]    <= 1'b0;
          sync_c[gi]    <= 1'b0;
          pin_clean[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= pin_raw[gi];
          sync_b[gi] <= sync_a[gi];
          sync_c[gi] <= sync_b[gi];
          if (sync_b[gi] == sync_c[gi]) begin
            pin_clean[gi] <= sync_c[gi];
          end
        end
      end
    end
  endgenerate

  logic [31:0] enc_limits;
  logic [31:0] digital_word;
  logic [7:0]  ext_digital;
  assign enc_limits   = {30'h0, pin_clean[1:0]};
  assign digital_word = {22'h0, pin_clean[5:4], 6'h0,
                         pin_clean[3:2]};
  assign ext_digital  = pin_clean[13:6];

  // Sum of squares; the square of a 16-bit value needs 32 bits, so the
  // sum is kept at 33 bits and clamped to the monitor's ceiling.
  logic [31:0] sq_sin;
  logic [31:0] sq_cos;
  logic [32:0] sq_sum;
  logic [31:0] amp_sq;
  assign sq_sin = 32'($signed(loop_in.encoder_sine) *
                      $signed(loop_in.encoder_sine));
  assign sq_cos = 32'($signed(loop_in.encoder_cosine) *
                      $signed(loop_in.encoder_cosine));
  assign sq_sum = {1'b0, sq_sin} + {1'b0, sq_cos};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      amp_sq <= 32'h0;
    end else if (sq_sum > {10'h0, AMP_SQ_MAX}) begin
      amp_sq <= {9'h0, AMP_SQ_MAX};
    end else begin
      amp_sq <= sq_sum[31:0];
    end
  end

  // Limit search results hold until the next search completes.
  logic [31:0] search_lower;
  logic [31:0] search_upper;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      search_lower <= 32'h0;
      search_upper <= 32'h0;
    end else if (limit_search_done) begin
      search_lower <= search_lower_in;
      search_upper <= search_upper_in;
    end
  end

  // Expansion analog inputs are signed 14-bit values, sign-extended.
  function automatic logic [15:0] ext_clamp(input logic [13:0] v);
    ext_clamp = {{2{v[13]}}, v};
  endfunction

  logic [15:0] ext_an1;
  logic [15:0] ext_an2;
  logic [15:0] ext_an3;
  logic [15:0] ext_an4;
  assign ext_an1 = ext_clamp(ext_analog_in1);
  assign ext_an2 = ext_clamp(ext_analog_in2);
  assign ext_an3 = ext_clamp(ext_analog_in3);
  assign ext_an4 = ext_clamp(ext_analog_in4);

  // The init-once flag is sticky: only reset clears it.
  logic init_once;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_once <= 1'b0;
    end else if (state_in.power_on_command) begin
      init_once <= 1'b1;
    end
  end

  logic [31:0] status_one;
  logic [31:0] status_two;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_one <= ST1_RESET;
      status_two <= ST2_RESET;
    end else begin
      status_one                <= ST1_RESET;
      status_one[ST1_POWERED]   <= state_in.powered;
      status_one[ST1_INIT_ONCE] <= init_once | state_in.power_on_command;
      status_one[ST1_HOMED]     <= state_in.homing_done_ok;
      status_one[ST1_MOVING]    <= state_in.moving;
      status_one[ST1_IN_WINDOW] <= state_in.in_window;
      status_one[ST1_WAITING]   <= state_in.waiting;
      status_one[ST1_SEQ_RUN]   <= state_in.seq_running;
      status_one[ST1_SEQ_EDIT]  <= state_in.seq_edit;
      status_one[ST1_ERROR]     <= state_in.error_mode;
      status_one[ST1_TRACE]     <= state_in.trace_busy;
      status_one[ST1_HOMING]    <= state_in.homing_active;
      status_one[ST1_WARNING]   <= state_in.warning;
      status_two                <= ST2_RESET;
      status_two[ST2_SEQ_ERR]   <= state_in.seq_error_label;
    end
  end

  // Read mux; writes are accepted and ignored, since every word is a
  // monitor of hardware state, live or, for the two search positions, held from the last search.
  logic [31:0] next_rdata;
  always_comb begin
    case (reg_addr)
      IDX_LUT_PHASE1:     next_rdata = {{16{loop_in.lut_phase1[15]}},
                                        loop_in.lut_phase1};
      IDX_LUT_PHASE2:     next_rdata = {{16{loop_in.lut_phase2[15]}},
                                        loop_in.lut_phase2};
      IDX_VOLTAGE_REF:    next_rdata = loop_in.voltage_ref_phase1;
      IDX_FORCE_AFTER:    next_rdata =
        {{16{loop_in.force_after_adv_filter[15]}},
         loop_in.force_after_adv_filter};
      IDX_REAL_FORCE:     next_rdata = {{16{loop_in.real_force[15]}},
                                        loop_in.real_force};
      IDX_FORCE_BEFORE:   next_rdata =
        {{16{loop_in.force_before_adv_filter[15]}},
         loop_in.force_before_adv_filter};
      IDX_SEARCH_LOWER:   next_rdata = search_lower;
      IDX_SEARCH_UPPER:   next_rdata = search_upper;
      IDX_ENC_SINE:       next_rdata = {{16{loop_in.encoder_sine[15]}},
                                        loop_in.encoder_sine};
      IDX_ENC_COSINE:     next_rdata = {{16{loop_in.encoder_cosine[15]}},
                                        loop_in.encoder_cosine};
      IDX_ENC_AMP_SQ:     next_rdata = amp_sq;
      IDX_ENC_LIMITS:     next_rdata = enc_limits;
      IDX_DIGITAL_INPUTS: next_rdata = digital_word;
      IDX_ANALOG_INPUT:   next_rdata = {{16{analog_in[15]}},
                                        analog_in};
      IDX_EXT_DIGITAL:    next_rdata = {24'h0, ext_digital};
      IDX_EXT_ANALOG1:    next_rdata = {{16{ext_an1[15]}}, ext_an1};
      IDX_EXT_ANALOG2:    next_rdata = {{16{ext_an2[15]}}, ext_an2};
      IDX_EXT_ANALOG3:    next_rdata = {{16{ext_an3[15]}}, ext_an3};
      IDX_EXT_ANALOG4:    next_rdata = {{16{ext_an4[15]}}, ext_an4};
      IDX_STATUS_ONE:     next_rdata = status_one;
      IDX_STATUS_TWO:     next_rdata = status_two;
      default:            next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // Assertions. A read takes two steps, so each watched read is a strobe
  // sequence followed by a check of the word one cycle later.

  present_bit_a: assert property (
    status_one[ST1_PRESENT])
    else $error("Present bit of status one is low.");

  init_sticky_a: assert property (
    state_in.power_on_command |=> status_one[ST1_INIT_ONCE] [*8])
    else $error("Init-once bit did not stay set.");

  init_rise_a: assert property (
    !init_once |=>
      status_one[ST1_INIT_ONCE] == $past(state_in.power_on_command))
    else $error("Init-once bit did not follow the first command.");

  powered_bit_a: assert property (
    ##1 status_one[ST1_POWERED] == $past(state_in.powered))
    else $error("Power bit does not follow powered state.");

  homed_bit_a: assert property (
    ##1 status_one[ST1_HOMED] == $past(state_in.homing_done_ok))
    else $error("Homed bit does not follow homing result.");

  moving_bit_a: assert property (
    ##1 status_one[ST1_MOVING] == $past(state_in.moving))
    else $error("Moving bit does not follow trajectory state.");

  window_bit_a: assert property (
    ##1 status_one[ST1_IN_WINDOW] == $past(state_in.in_window))
    else $error("Window bit does not follow window state.");

  waiting_bit_a: assert property (
    ##1 status_one[ST1_WAITING] == $past(state_in.waiting))
    else $error("Waiting bit does not follow waiting state.");

  seq_run_bit_a: assert property (
    ##1 status_one[ST1_SEQ_RUN] == $past(state_in.seq_running))
    else $error("Sequence bit does not follow sequence state.");

  seq_edit_bit_a: assert property (
    ##1 status_one[ST1_SEQ_EDIT] == $past(state_in.seq_edit))
    else $error("Edit bit does not follow edit mode.");

  error_bit_a: assert property (
    ##1 status_one[ST1_ERROR] == $past(state_in.error_mode))
    else $error("Error bit does not follow error mode.");

  trace_bit_a: assert property (
    state_in.trace_busy [*2] |-> status_one[ST1_TRACE])
    else $error("Trace busy bit dropped during acquisition.");

  homing_bit_a: assert property (
    ##1 status_one[ST1_HOMING] == $past(state_in.homing_active))
    else $error("Homing bit does not follow homing state.");

  warning_bit_a: assert property (
    ##1 status_one[ST1_WARNING] == $past(state_in.warning))
    else $error("Warning bit does not follow warning state.");

  st1_spare_a: assert property (
    status_one[31:24] == 8'h0 && status_one[22:14] == 9'h0
      && !status_one[12] && !status_one[6])
    else $error("Unused bits of status one are set.");

  status_two_a: assert property (
    status_two[31:1] == 31'h0)
    else $error("Status two has stray bits.");

  seq_err_bit_a: assert property (
    ##1 status_two[ST2_SEQ_ERR] == $past(state_in.seq_error_label))
    else $error("Sequence error bit does not follow its source.");

  amp_limit_a: assert property (
    amp_sq <= {9'h0, AMP_SQ_MAX})
    else $error("Amplitude sum exceeds ceiling.");

  digital_gap_a: assert property (
    digital_word[7:2] == 6'h0 && digital_word[31:10] == 22'h0)
    else $error("Digital input word has stray bits.");

  search_hold_a: assert property (
    !limit_search_done |=> $stable(search_lower))
    else $error("Search position changed without a search.");

  read_only_a: assert property (
    reg_wr && !state_in.power_on_command && !state_in.powered
    |=> status_one[ST1_POWERED] == 1'b0)
    else $error("Write disturbed status one.");

  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("Read data is not zero outside a read.");

  sequence st1_read_s;
    reg_rd && reg_addr == IDX_STATUS_ONE;
  endsequence
  sequence st2_read_s;
    reg_rd && reg_addr == IDX_STATUS_TWO;
  endsequence
  sequence sine_read_s;
    reg_rd && reg_addr == IDX_ENC_SINE;
  endsequence
  sequence amp_read_s;
    reg_rd && reg_addr == IDX_ENC_AMP_SQ;
  endsequence
  sequence lower_read_s;
    reg_rd && reg_addr == IDX_SEARCH_LOWER;
  endsequence
  sequence din_read_s;
    reg_rd && reg_addr == IDX_DIGITAL_INPUTS;
  endsequence
  sequence ain_read_s;
    reg_rd && reg_addr == IDX_ANALOG_INPUT;
  endsequence
  sequence xan1_read_s;
    reg_rd && reg_addr == IDX_EXT_ANALOG1;
  endsequence

  st1_read_a: assert property (
    st1_read_s |=> reg_rdata == $past(status_one))
    else $error("Status one read does not match the word.");

  st2_read_a: assert property (
    st2_read_s |=> reg_rdata == $past(status_two))
    else $error("Status two read does not match the word.");

  sine_read_a: assert property (
    sine_read_s |=> reg_rdata[15:0] == $past(loop_in.encoder_sine)
      && reg_rdata[31:16] == {16{reg_rdata[15]}})
    else $error("Sine read does not match the monitor.");

  amp_read_a: assert property (
    amp_read_s |=> reg_rdata == $past(amp_sq))
    else $error("Amplitude read does not match the monitor.");

  lower_read_a: assert property (
    lower_read_s |=> reg_rdata == $past(search_lower))
    else $error("Lower position read does not match the capture.");

  din_read_a: assert property (
    din_read_s |=> reg_rdata == $past(digital_word))
    else $error("Digital input read does not match the word.");

  ain_read_a: assert property (
    ain_read_s |=> reg_rdata[15:0] == $past(analog_in)
      && reg_rdata[31:16] == {16{reg_rdata[15]}})
    else $error("Analog input read does not match the monitor.");

  xan1_read_a: assert property (
    xan1_read_s |=> reg_rdata[13:0] == $past(ext_analog_in1)
      && reg_rdata[31:14] == {18{reg_rdata[13]}})
    else $error("Expansion analog read does not match the input.");

endmodule // mms_bank
